// file: core/irq_bank_pkg.sv
// package: register indices, bit positions, reset values and edge encodings of the irq bank
package irq_bank_pkg;
  localparam logic [2:0] ADDR_EDGE  = 3'h0;
  localparam logic [2:0] ADDR_CTRLA = 3'h1;
  localparam logic [2:0] ADDR_CTRLB = 3'h2;
  localparam logic [2:0] ADDR_CTRLC = 3'h3;
  localparam logic [2:0] ADDR_GRPLO = 3'h4;
  localparam logic [2:0] ADDR_GRPHI = 3'h5;
  localparam logic [2:0] ADDR_ISTAT = 3'h6;
  localparam logic [2:0] ADDR_IENA  = 3'h7;

  localparam logic [7:0] RST_REG    = 8'h00;
  localparam logic [7:0] EDGE_MASK  = 8'h0f;
  localparam logic [7:0] CTRLA_MASK = 8'h7f;
  localparam logic [7:0] CTRLB_MASK = 8'hdd;

  // edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // bit positions
  localparam int PIN_A_SEL   = 0;
  localparam int PIN_B_SEL   = 2;
  localparam int GLOBAL_EN   = 0;
  localparam int PIN_A_EN    = 1;
  localparam int PIN_B_EN    = 2;
  localparam int USB_EN      = 3;
  localparam int PIN_A_FLAG  = 4;
  localparam int PIN_B_FLAG  = 5;
  localparam int USB_FLAG    = 6;
  localparam int LV_EN       = 0;
  localparam int G0_EN       = 2;
  localparam int G1_EN       = 3;
  localparam int LV_FLAG     = 4;
  localparam int G0_FLAG     = 6;
  localparam int G1_FLAG     = 7;
  localparam int G2_EN       = 0;
  localparam int G3_EN       = 1;
  localparam int SIM_EN      = 2;
  localparam int SP2_EN      = 3;
  localparam int G2_FLAG     = 4;
  localparam int G3_FLAG     = 5;
  localparam int SIM_FLAG    = 6;
  localparam int SP2_FLAG    = 7;
  localparam int FLAG_OFS    = 4;

  // bus-level event status bits
  localparam int NUM_SRC     = 8;
  localparam int EV_PIN_A    = 0;
  localparam int EV_PIN_B    = 1;
  localparam int EV_USB      = 2;
  localparam int EV_LV       = 3;
  localparam int EV_G0       = 4;
  localparam int EV_G1       = 5;
  localparam int EV_SIM      = 6;
  localparam int EV_SP2      = 7;
endpackage

// file: core/irq_flag_enable_bank.sv
// interrupt flag, enable and edge-select bank with register port
`timescale 1ns/1ps
// Function
// - pin b trigger select at edge bits 3:2: off, rise, fall, both
// - pin a trigger select at edge bits 1:0 with the same coding
// - edge register bits 7:4 always read zero
// - hardware sets flags on events; control flags and all enables read and write, event status bits clear on a written one
// - three primary control, two group and one edge-select register
// - sources: two pins, timers, low voltage, serial module, serial port, usb
// - accepted request raises a level to suspend the processor program
// - usb flag at control a bit 6, its enable at bit 3
// - low-voltage flag at control b bit 4, enable at bit 0
// - group 1 and 0 flags at control b bits 7 and 6
// - group 0 and 1 enables at control b bits 2 and 3
// - control c: port2 flag bit 7, serial module flag bit 6, enables 3 and 2
module irq_flag_enable_bank
  import irq_bank_pkg::*;
(
  // clock and raw reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // external pins, asynchronous to clk
  input  wire logic       ext_pin_a,
  input  wire logic       ext_pin_b,
  // internal sources on clk
  input  wire logic       usb_event,
  input  wire logic       lowvolt_event,
  input  wire logic       serial_module_event,
  input  wire logic       serial_port2_event,
  input  wire logic [3:0] timer_p_match,
  input  wire logic [3:0] timer_a_match,
  // request levels
  output logic            cpu_irq_req,
  output logic            irq_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pin_a_sync;
    logic [1:0] pin_b_sync;
    logic       pin_a_prev;
    logic       pin_b_prev;
    logic [7:0] edge_sel;
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] ctrl_c;
    logic [7:0] grp_lo;
    logic [7:0] grp_hi;
    logic [7:0] ev_stat;
    logic [7:0] ev_ena;
    logic [7:0] rdata;
    logic       cpu_irq;
    logic       irq;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [1:0] rst_sync_q;
  logic [1:0] rst_sync_d;
  logic       rst_core_n;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                    input logic prev);
    logic rise;
    logic fall;
    rise = now & ~prev;
    fall = ~now & prev;
    unique case (sel)
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
    endcase
  endfunction

  // any timer flag whose paired enable is set; flags high nibble, enables low
  function automatic logic grp_any(input logic [7:0] r);
    grp_any = |(r[7:4] & r[3:0]);
  endfunction

  // comparator matches land in the flag nibble: p match on the even bit, a match on the odd
  function automatic logic [7:0] timer_set(input logic [7:0] r, input logic [1:0] p_hit,
                                           input logic [1:0] a_hit);
    logic [7:0] t;
    t = r;
    t[FLAG_OFS]     = r[FLAG_OFS] | p_hit[0];
    t[FLAG_OFS + 1] = r[FLAG_OFS + 1] | a_hit[0];
    t[FLAG_OFS + 2] = r[FLAG_OFS + 2] | p_hit[1];
    t[FLAG_OFS + 3] = r[FLAG_OFS + 3] | a_hit[1];
    timer_set = t;
  endfunction

  // one term per source, flag and own enable; the caller applies the global enable
  function automatic logic src_pending(input logic [7:0] a, input logic [7:0] b,
                                       input logic [7:0] c);
    logic pin_a;
    logic pin_b;
    logic usb;
    logic lowvolt;
    logic grp0;
    logic grp1;
    logic grp2;
    logic grp3;
    logic sim;
    logic sp2;
    pin_a   = a[PIN_A_FLAG] & a[PIN_A_EN];
    pin_b   = a[PIN_B_FLAG] & a[PIN_B_EN];
    usb     = a[USB_FLAG] & a[USB_EN];
    lowvolt = b[LV_FLAG] & b[LV_EN];
    grp0    = b[G0_FLAG] & b[G0_EN];
    grp1    = b[G1_FLAG] & b[G1_EN];
    grp2    = c[G2_FLAG] & c[G2_EN];
    grp3    = c[G3_FLAG] & c[G3_EN];
    sim     = c[SIM_FLAG] & c[SIM_EN];
    sp2     = c[SP2_FLAG] & c[SP2_EN];
    src_pending = pin_a | pin_b | usb | lowvolt | grp0 | grp1 | grp2 | grp3 | sim | sp2;
  endfunction

  // read mux over the current register image
  function automatic logic [7:0] read_reg(input logic [2:0] addr, input state_t s);
    logic [7:0] r;
    r = RST_REG;
    unique case (addr)
      ADDR_EDGE:  r = s.edge_sel;
      ADDR_CTRLA: r = s.ctrl_a;
      ADDR_CTRLB: r = s.ctrl_b;
      ADDR_CTRLC: r = s.ctrl_c;
      ADDR_GRPLO: r = s.grp_lo;
      ADDR_GRPHI: r = s.grp_hi;
      ADDR_ISTAT: r = s.ev_stat;
      ADDR_IENA:  r = s.ev_ena;
    endcase
    read_reg = r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_SRC-1:0] ev;
    logic [7:0]         a;
    logic [7:0]         b;
    logic [7:0]         c;
    logic [7:0]         lo;
    logic [7:0]         hi;
    logic               hit_a;
    logic               hit_b;
    logic               pend;
    s_d   = s_q;
    ev    = '0;
    hit_a = 1'b0;
    hit_b = 1'b0;
    pend  = 1'b0;

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    s_d.pin_a_sync = {s_q.pin_a_sync[0], ext_pin_a};
    s_d.pin_b_sync = {s_q.pin_b_sync[0], ext_pin_b};
    s_d.pin_a_prev = s_q.pin_a_sync[1];
    s_d.pin_b_prev = s_q.pin_b_sync[1];
    hit_a = edge_hit(s_q.edge_sel[PIN_A_SEL+:2], s_q.pin_a_sync[1], s_q.pin_a_prev);
    hit_b = edge_hit(s_q.edge_sel[PIN_B_SEL+:2], s_q.pin_b_sync[1], s_q.pin_b_prev);

    // ----------------------------------------------------------------
    // software writes
    // ----------------------------------------------------------------
    // software writes first, hardware sets after so a same-cycle event wins
    a  = s_q.ctrl_a;
    b  = s_q.ctrl_b;
    c  = s_q.ctrl_c;
    lo = s_q.grp_lo;
    hi = s_q.grp_hi;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_EDGE:  s_d.edge_sel = reg_wdata & EDGE_MASK;
        ADDR_CTRLA: a = reg_wdata & CTRLA_MASK;
        ADDR_CTRLB: b = reg_wdata & CTRLB_MASK;
        ADDR_CTRLC: c = reg_wdata;
        ADDR_GRPLO: lo = reg_wdata;
        ADDR_GRPHI: hi = reg_wdata;
        ADDR_ISTAT: ;
        ADDR_IENA:  s_d.ev_ena = reg_wdata;
      endcase
    end

    // ----------------------------------------------------------------
    // hardware sets
    // ----------------------------------------------------------------
    // timers 0/1 feed the low group register, timers 2/3 the high one
    lo = timer_set(lo, timer_p_match[1:0], timer_a_match[1:0]);
    hi = timer_set(hi, timer_p_match[3:2], timer_a_match[3:2]);

    // hardware sets
    ev[EV_PIN_A] = hit_a;
    ev[EV_PIN_B] = hit_b;
    ev[EV_USB]   = usb_event;
    ev[EV_LV]    = lowvolt_event;
    ev[EV_G0]    = grp_any(s_q.grp_lo) & ~s_q.ctrl_b[G0_FLAG];
    ev[EV_G1]    = grp_any(s_q.grp_hi) & ~s_q.ctrl_b[G1_FLAG];
    ev[EV_SIM]   = serial_module_event;
    ev[EV_SP2]   = serial_port2_event;

    a[PIN_A_FLAG] = a[PIN_A_FLAG] | ev[EV_PIN_A];
    a[PIN_B_FLAG] = a[PIN_B_FLAG] | ev[EV_PIN_B];
    a[USB_FLAG]   = a[USB_FLAG] | ev[EV_USB];
    b[LV_FLAG]    = b[LV_FLAG] | ev[EV_LV];
    b[G0_FLAG]    = b[G0_FLAG] | ev[EV_G0];
    b[G1_FLAG]    = b[G1_FLAG] | ev[EV_G1];
    c[SIM_FLAG]   = c[SIM_FLAG] | ev[EV_SIM];
    c[SP2_FLAG]   = c[SP2_FLAG] | ev[EV_SP2];
    s_d.ctrl_a = a;
    s_d.ctrl_b = b;
    s_d.ctrl_c = c;
    s_d.grp_lo = lo;
    s_d.grp_hi = hi;

    // ----------------------------------------------------------------
    // event status and level interrupt
    // ----------------------------------------------------------------
    // sticky event status, write-one clear; set wins over clear
    s_d.ev_stat = s_q.ev_stat;
    if (reg_wr && reg_addr == ADDR_ISTAT) begin
      s_d.ev_stat = s_q.ev_stat & ~reg_wdata;
    end
    s_d.ev_stat = s_d.ev_stat | ev;
    s_d.irq = |(s_d.ev_stat & s_d.ev_ena);

    // ----------------------------------------------------------------
    // processor request
    // ----------------------------------------------------------------
    // built from next flag values so the request rises with the flag
    pend        = src_pending(a, b, c);
    s_d.cpu_irq = pend & a[GLOBAL_EN];

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // read data only in the cycle after the strobe
    s_d.rdata = RST_REG;
    if (reg_rd) begin
      s_d.rdata = read_reg(reg_addr, s_q);
    end
  end

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // raw reset asserts at once; release is retimed so that all state leaves
  // reset on the same clock edge
  assign rst_sync_d = {rst_sync_q[0], 1'b1};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= '0;
    end else begin
      rst_sync_q <= rst_sync_d;
    end
  end

  assign rst_core_n = rst_sync_q[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // every field clears to zero, the reset value of all registers
  always_ff @(posedge clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign reg_rdata   = s_q.rdata;
  assign cpu_irq_req = s_q.cpu_irq;
  assign irq_out     = s_q.irq;

endmodule

// file: test/irq_bank_sva.sv
// assertion checker on the irq flag and enable bank ports
`timescale 1ns/1ps
module irq_bank_sva
  import irq_bank_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       usb_event,
  input wire logic       lowvolt_event,
  input wire logic       serial_module_event,
  input wire logic       serial_port2_event,
  input wire logic       cpu_irq_req
);
  // global enable is only ever changed by software writes
  logic glob_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) glob_q <= 1'b0;
    else if (reg_wr && reg_addr == ADDR_CTRLA) glob_q <= reg_wdata[GLOBAL_EN];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_edge_high_zero: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_EDGE |-> reg_rdata[7:4] == 4'h0)
    else $error("edge select upper bits not zero");
  a_ctrlb_gap_zero: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_CTRLB |-> (reg_rdata & ~CTRLB_MASK) == 8'h00)
    else $error("control b unused bits not zero");
  a_edge_sel_back: assert property (reg_wr && reg_addr == ADDR_EDGE ##2 reg_rd && reg_addr == ADDR_EDGE |=> reg_rdata == ($past(reg_wdata, 3) & EDGE_MASK))
    else $error("edge select readback wrong");
  a_usb_flag_set: assert property (usb_event ##2 reg_rd && reg_addr == ADDR_CTRLA |=> reg_rdata[USB_FLAG])
    else $error("usb flag not set");
  a_lv_flag_set: assert property (lowvolt_event ##2 reg_rd && reg_addr == ADDR_CTRLB |=> reg_rdata[LV_FLAG])
    else $error("low voltage flag not set");
  a_sim_flag_set: assert property (serial_module_event ##2 reg_rd && reg_addr == ADDR_CTRLC |=> reg_rdata[SIM_FLAG])
    else $error("serial module flag not set");
  a_sp2_flag_set: assert property (serial_port2_event ##2 reg_rd && reg_addr == ADDR_CTRLC |=> reg_rdata[SP2_FLAG])
    else $error("serial port flag not set");
  a_irq_needs_glob: assert property (cpu_irq_req |-> glob_q)
    else $error("request without global enable");
endmodule

// file: test/irq_flag_enable_bank_tb.sv
// self-checking bench for the irq flag and enable bank
`timescale 1ns/1ps
module irq_flag_enable_bank_tb
  import irq_bank_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wd = 8'h00, d;
  logic [1:0] pin = 2'h0;
  logic [3:0] ev = 4'h0, tp = 4'h0, ta = 4'h0;
  wire logic [7:0] rdata;
  wire logic cpu, irq;
  int n_fail = 0, checks = 0;
  logic [2:0] ev_a [4] = '{ADDR_CTRLA, ADDR_CTRLB, ADDR_CTRLC, ADDR_CTRLC};
  logic [7:0] ev_b [4] = '{8'h40, 8'h10, 8'h40, 8'h80};
  logic [7:0] msk [6] = '{EDGE_MASK, CTRLA_MASK, CTRLB_MASK, 8'hff, 8'hff, 8'hff};
  irq_flag_enable_bank uut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .ext_pin_a(pin[0]), .ext_pin_b(pin[1]),
    .usb_event(ev[0]), .lowvolt_event(ev[1]), .serial_module_event(ev[2]),
    .serial_port2_event(ev[3]), .timer_p_match(tp), .timer_a_match(ta),
    .cpu_irq_req(cpu), .irq_out(irq));
  always #25 clk = ~clk;
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrt(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk) begin wr <= 1'b1; addr <= a; wd <= v; end
    @(posedge clk) wr <= 1'b0;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk) begin rd <= 1'b1; addr <= a; end
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] pin_exp(logic [1:0] c, logic rise, int p);
    return 8'((rise ? c[0] : c[1]) << (PIN_A_FLAG + p));
  endfunction
  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(1016));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 8; a++) rdc(3'(a), 8'h00);
    for (int a = 0; a < 6; a++) begin
      d = 8'($urandom);
      wrt(3'(a), d);
      rdc(3'(a), d & msk[a]);
    end
    for (int a = 5; a >= 0; a--) wrt(3'(a), 8'h00);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 4; c++) begin
        wrt(ADDR_EDGE, 8'(c << (2 * p)));
        for (int v = 1; v >= 0; v--) begin
          @(posedge clk) pin[p] <= v[0];
          repeat (5) @(posedge clk);
          rdc(ADDR_CTRLA, pin_exp(c[1:0], v[0], p));
          wrt(ADDR_CTRLA, 8'h00);
        end
      end
    // both group flags set from enabled comparator flags: timer 0 p match low, timer 2 a match high
    wrt(ADDR_GRPLO, 8'h01);
    wrt(ADDR_GRPHI, 8'h02);
    @(posedge clk) begin tp <= 4'h1; ta <= 4'h4; end
    @(posedge clk) begin tp <= 4'h0; ta <= 4'h0; end
    rdc(ADDR_GRPLO, 8'h11);
    rdc(ADDR_GRPHI, 8'h22);
    rdc(ADDR_CTRLB, 8'hc0);
    wrt(ADDR_GRPLO, 8'h00);
    wrt(ADDR_GRPHI, 8'h00);
    wrt(ADDR_CTRLB, 8'h00);
    wrt(ADDR_ISTAT, 8'hff);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) ev[k] <= 1'b1;
      @(posedge clk) ev[k] <= 1'b0;
      rdc(ev_a[k], ev_b[k]);
      wrt(ev_a[k], 8'h00);
    end
    rdc(ADDR_ISTAT, 8'hcc);
    settle();
    chk({7'h0, irq}, 8'h00);
    wrt(ADDR_IENA, 8'h04);
    settle();
    chk({7'h0, irq}, 8'h01);
    wrt(ADDR_ISTAT, 8'h04);
    settle();
    chk({7'h0, irq}, 8'h00);
    wrt(ADDR_CTRLA, 8'h08);
    @(posedge clk) ev[0] <= 1'b1;
    @(posedge clk) ev[0] <= 1'b0;
    settle();
    chk({7'h0, cpu}, 8'h00);
    wrt(ADDR_CTRLA, 8'h49);
    settle();
    chk({7'h0, cpu}, 8'h01);
    wrt(ADDR_CTRLA, 8'h09);
    settle();
    chk({7'h0, cpu}, 8'h00);
    wrt(ADDR_CTRLB, 8'h44);
    settle();
    chk({7'h0, cpu}, 8'h01);
    wrt(ADDR_CTRLB, 8'h00);
    wrt(ADDR_CTRLC, 8'h44);
    settle();
    chk({7'h0, cpu}, 8'h01);
    wrt(ADDR_CTRLC, 8'h00);
    settle();
    chk({7'h0, cpu}, 8'h00);
    tally_and_finish();
  end
endmodule
bind irq_flag_enable_bank irq_bank_sva u_sva (.clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .usb_event, .lowvolt_event, .serial_module_event,
  .serial_port2_event, .cpu_irq_req);
